// [verilog/gpb_defines.svh]
// offsets, reset values and sizes of the bidirectional port bank
// assumes an 8-bit special register address and 4-bit register data
`ifndef GPB_DEFINES_SVH
`define GPB_DEFINES_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define GPB_PORT_W      4
`define GPB_NUM_PORTS   9
`define GPB_ADDR_W      8
`define GPB_GROUP1_CNT  6

// ****************************************************************
// data register offsets (index 7 is port 9, index 8 is port a)
// ****************************************************************
`define GPB_OFS_PORT0_DATA  8'h00
`define GPB_OFS_PORT1_DATA  8'h01
`define GPB_OFS_PORT2_DATA  8'h02
`define GPB_OFS_PORT3_DATA  8'h03
`define GPB_OFS_PORT4_DATA  8'h04
`define GPB_OFS_PORT5_DATA  8'h05
`define GPB_OFS_PORT6_DATA  8'h06
`define GPB_OFS_PORT9_DATA  8'h1C
`define GPB_OFS_PORTA_DATA  8'h1D

// ****************************************************************
// direction register offsets
// ****************************************************************
`define GPB_OFS_PORT0_DIR   8'h0C
`define GPB_OFS_PORT1_DIR   8'h0D
`define GPB_OFS_PORT2_DIR   8'h0E
`define GPB_OFS_PORT3_DIR   8'h0F
`define GPB_OFS_PORT4_DIR   8'h10
`define GPB_OFS_PORT5_DIR   8'h11
`define GPB_OFS_PORT6_DIR   8'h12
`define GPB_OFS_PORT9_DIR   8'h1E
`define GPB_OFS_PORTA_DIR   8'h1F

// ****************************************************************
// reset values
// ****************************************************************
`define GPB_DATA_RST   4'h0
`define GPB_DIR_RST    4'h0
`define GPB_RDATA_RST  4'h0

`endif

// [verilog/gpb_pkg.sv]
// types shared by the port bank, its board model and its bench
// assumes gpb_defines.svh is on the include path
`include "gpb_defines.svh"

package gpb_pkg;

    // one special register access from the cpu, one cycle long
    typedef struct packed {
        logic                     wr;     // write strobe, marks state 2
        logic                     rd;     // read strobe
        logic [`GPB_ADDR_W-1:0]   addr;   // register offset
        logic [`GPB_PORT_W-1:0]   wdata;  // write data
    } gpb_sfr_req_t;

    // one 4-bit nibble per port
    typedef logic [`GPB_NUM_PORTS-1:0][`GPB_PORT_W-1:0] gpb_nibbles_t;

endpackage

// [verilog/gpb_port_cell.sv]
// one 4-bit bidirectional port: data, direction, pin sync and read mux
// assumes strobes arrive on clk_sys_i and pins are asynchronous to it
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defines.svh"

module gpb_port_cell #(
    parameter logic DIR_OUT_LVL = 1'b1   // direction bit level that selects output
) (
    // clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    // register side
    input  wire logic                   wr_data_i,
    input  wire logic                   wr_dir_i,
    input  wire logic [`GPB_PORT_W-1:0] wdata_i,
    output logic      [`GPB_PORT_W-1:0] rd_o,
    // pin side
    input  wire logic [`GPB_PORT_W-1:0] pin_i,
    output logic      [`GPB_PORT_W-1:0] pin_o,
    output logic      [`GPB_PORT_W-1:0] pin_oe_n_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [`GPB_PORT_W-1:0] data;          // data register, also drives pins
    logic [`GPB_PORT_W-1:0] dir;           // direction register
    logic [`GPB_PORT_W-1:0] next_data;
    logic [`GPB_PORT_W-1:0] next_dir;
    logic [`GPB_PORT_W-1:0] next_oe_n;
    logic [`GPB_PORT_W-1:0] oe_n;          // registered output enable, low drives
    logic [`GPB_PORT_W-1:0] pin_meta;      // first sync stage, read by stage two only
    logic [`GPB_PORT_W-1:0] pin_sync;      // second sync stage
    logic [`GPB_PORT_W-1:0] out_mask;      // 1 where the bit is an output

    // polarity differs between port groups; mask is per bit
    assign out_mask = DIR_OUT_LVL ? dir : ~dir;

    // next values of the register and enable state
    always_comb begin
        next_data = wr_data_i ? wdata_i : data;
        next_dir  = wr_dir_i ? wdata_i : dir;
        // enable is computed from the next direction so it flips on the write edge
        next_oe_n = DIR_OUT_LVL ? ~next_dir : next_dir;
    end

    // registers; pins follow data on the same edge that takes the write
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            data <= `GPB_DATA_RST;
            dir  <= `GPB_DIR_RST;
            oe_n <= DIR_OUT_LVL ? ~`GPB_DIR_RST : `GPB_DIR_RST;
        end else begin
            data <= next_data;
            dir  <= next_dir;
            oe_n <= next_oe_n;
        end
    end

    // two-stage synchroniser; pins are asynchronous to clk_sys_i
    // no reset: it keeps sampling through reset, so input reads are valid at once after release
    always_ff @(posedge clk_sys_i) begin
        pin_meta <= pin_i;
        pin_sync <= pin_meta;
    end

    // output bits read the latch, input bits read the pin level
    assign rd_o       = (data & out_mask) | (pin_sync & ~out_mask);
    assign pin_o      = data;
    assign pin_oe_n_o = oe_n;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_write_to_pin: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_data_i |=> (pin_o == $past(wdata_i)))
        else $error("pin did not take written data on the write edge");

    a_data_holds: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !wr_data_i |=> $stable(pin_o))
        else $error("data register changed without a write");

    a_dir_to_enable: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        wr_dir_i |=> (pin_oe_n_o == (DIR_OUT_LVL ? ~$past(wdata_i) : $past(wdata_i))))
        else $error("output enable does not follow direction polarity");

    a_dir_keeps_data: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_dir_i && !wr_data_i) |=> (pin_o == $past(pin_o)))
        else $error("direction write disturbed port data");

    a_read_latched: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        ((rd_o ^ pin_o) & ~pin_oe_n_o) == 4'h0)
        else $error("driven bit did not read back latched data");

    a_read_pin_level: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        $stable(pin_oe_n_o) |-> (((rd_o ^ $past(pin_i, 2)) & pin_oe_n_o) == 4'h0))
        else $error("input bit did not read the sampled pin level");

endmodule
`default_nettype wire

// [verilog/gpb_port_bank.sv]
// bank of nine 4-bit bidirectional ports behind the cpu special register port
// Summary of operation
// - four-bit ports; this bank is nine bidirectional
// - each port has readable writable data register
// - ports 0-5: direction 1 output, 0 input
// - ports 6, 9, a: direction 0 output
// - output pins drive data register bits
// - output bits read back latched data
// - input bits read the sampled pin level
// - reset clears all data registers
// - pins change on the write-state clock edge
// - reset clears directions: 0-5 in, others out
// assumes the cpu gives one-cycle wr/rd strobes on clk_sys_i, wr in state 2
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defines.svh"

module gpb_port_bank (
    // clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    // cpu special register port
    input  wire gpb_pkg::gpb_sfr_req_t sfr_req_i,
    output logic [`GPB_PORT_W-1:0]     rdata_o,
    // pins, index 0..6 ports 0..6, 7 port 9, 8 port a
    input  wire gpb_pkg::gpb_nibbles_t pin_i,
    output gpb_pkg::gpb_nibbles_t      pin_o,
    output gpb_pkg::gpb_nibbles_t      pin_oe_n_o
);

    // ****************************************************************
    // address map
    // ****************************************************************
    localparam logic [`GPB_ADDR_W-1:0] DATA_OFS [`GPB_NUM_PORTS] = '{
        `GPB_OFS_PORT0_DATA, `GPB_OFS_PORT1_DATA, `GPB_OFS_PORT2_DATA,
        `GPB_OFS_PORT3_DATA, `GPB_OFS_PORT4_DATA, `GPB_OFS_PORT5_DATA,
        `GPB_OFS_PORT6_DATA, `GPB_OFS_PORT9_DATA, `GPB_OFS_PORTA_DATA};
    localparam logic [`GPB_ADDR_W-1:0] DIR_OFS [`GPB_NUM_PORTS] = '{
        `GPB_OFS_PORT0_DIR, `GPB_OFS_PORT1_DIR, `GPB_OFS_PORT2_DIR,
        `GPB_OFS_PORT3_DIR, `GPB_OFS_PORT4_DIR, `GPB_OFS_PORT5_DIR,
        `GPB_OFS_PORT6_DIR, `GPB_OFS_PORT9_DIR, `GPB_OFS_PORTA_DIR};

    // ****************************************************************
    // per-port decode and cells
    // ****************************************************************
    logic [`GPB_NUM_PORTS-1:0] wr_data;    // write strobe per data register
    logic [`GPB_NUM_PORTS-1:0] wr_dir;     // write strobe per direction register
    logic [`GPB_NUM_PORTS-1:0] hit_data;   // address matches a data register
    logic [`GPB_NUM_PORTS-1:0] hit_dir;    // address matches a direction register
    gpb_pkg::gpb_nibbles_t     cell_rd;    // read value offered by each cell
    gpb_pkg::gpb_nibbles_t     cell_dir;   // direction value of each cell, for readback

    genvar gi;
    generate
        for (gi = 0; gi < `GPB_NUM_PORTS; gi++) begin : g_port
            assign hit_data[gi] = (sfr_req_i.addr == DATA_OFS[gi]);
            assign hit_dir[gi]  = (sfr_req_i.addr == DIR_OFS[gi]);
            assign wr_data[gi]  = sfr_req_i.wr && hit_data[gi];
            assign wr_dir[gi]   = sfr_req_i.wr && hit_dir[gi];

            // group one below the count, inverted polarity at and above it
            gpb_port_cell #(
                .DIR_OUT_LVL ((gi < `GPB_GROUP1_CNT) ? 1'b1 : 1'b0)
            ) u_cell (
                .clk_sys_i  (clk_sys_i),
                .rst_i      (rst_i),
                .wr_data_i  (wr_data[gi]),
                .wr_dir_i   (wr_dir[gi]),
                .wdata_i    (sfr_req_i.wdata),
                .rd_o       (cell_rd[gi]),
                .pin_i      (pin_i[gi]),
                .pin_o      (pin_o[gi]),
                .pin_oe_n_o (pin_oe_n_o[gi])
            );

            // direction readback recovered from the registered enable
            assign cell_dir[gi] = (gi < `GPB_GROUP1_CNT) ? ~pin_oe_n_o[gi] : pin_oe_n_o[gi];
        end
    endgenerate

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [`GPB_PORT_W-1:0] next_rdata;

    // unmapped offsets read as zero; rdata stands until the next read
    always_comb begin
        next_rdata = rdata_o;
        if (sfr_req_i.rd) begin
            next_rdata = `GPB_RDATA_RST;
            for (int i = 0; i < `GPB_NUM_PORTS; i++) begin
                if (hit_data[i]) begin
                    next_rdata = next_rdata | cell_rd[i];
                end
                if (hit_dir[i]) begin
                    next_rdata = next_rdata | cell_dir[i];
                end
            end
        end
    end

    // registered so the bus sees a clean one-cycle latency
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= `GPB_RDATA_RST;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_read_data_path: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (sfr_req_i.rd && hit_data[1]) |=> (rdata_o == $past(cell_rd[1])))
        else $error("port 1 data read returned wrong value");

    a_group_two_out: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (sfr_req_i.wr && hit_dir[6] && sfr_req_i.wdata == 4'h0)
        |=> (pin_oe_n_o[6] == 4'h0))
        else $error("port 6 direction 0 did not drive");

    a_group_one_in: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (sfr_req_i.wr && hit_dir[0] && sfr_req_i.wdata == 4'h0)
        |=> (pin_oe_n_o[0] == 4'hF))
        else $error("port 0 direction 0 did not release pins");

    a_unmapped_zero: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        (sfr_req_i.rd && hit_data == '0 && hit_dir == '0) |=> (rdata_o == 4'h0))
        else $error("unmapped read did not return zero");

endmodule
`default_nettype wire

// [test/gpb_pin_board.sv]
// board model: resolves every port pin from the bank's drive and the board's drive
// assumes pin_oe_n_o is low while the bank drives a pin
`timescale 1ns/1ps
`default_nettype none

module gpb_pin_board (
    // bank side
    input  wire gpb_pkg::gpb_nibbles_t pin_o,
    input  wire gpb_pkg::gpb_nibbles_t pin_oe_n_o,
    // board drive
    input  wire gpb_pkg::gpb_nibbles_t board_i,
    output var  gpb_pkg::gpb_nibbles_t pin_i
);
    // a driven bit shows the bank level; an undriven bit shows the board level
    assign pin_i = (pin_o & ~pin_oe_n_o) | (board_i & pin_oe_n_o);
endmodule

`default_nettype wire

// [test/gpb_port_bank_bench.sv]
// self-checking bench for the port bank: table of port cases, then reset and edge cases
// assumes gpb_defines.svh on the include path; inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defines.svh"

module gpb_port_bank_bench;
    // one table row: port index, direction, data, board level, expected read and enables
    typedef struct { int idx; logic [3:0] dir, data, board, rd, oe_n; } gpb_row_t;

    // ****************************************************************
    // signals and instances
    // ****************************************************************
    logic                  clk_sys_i = 1'b0;  // system clock
    logic                  rst_i     = 1'b1;  // reset held from time zero
    gpb_pkg::gpb_sfr_req_t sfr_req   = '0;    // cpu request
    gpb_pkg::gpb_nibbles_t board     = '0;    // board drive per pin
    gpb_pkg::gpb_nibbles_t pin_i, pin_o, pin_oe_n;
    logic [3:0]            rdata;
    int                    n_mismatch = 0;
    int                    comparisons = 0;
    logic [7:0] data_ofs [9] = '{`GPB_OFS_PORT0_DATA, `GPB_OFS_PORT1_DATA, `GPB_OFS_PORT2_DATA,
        `GPB_OFS_PORT3_DATA, `GPB_OFS_PORT4_DATA, `GPB_OFS_PORT5_DATA, `GPB_OFS_PORT6_DATA,
        `GPB_OFS_PORT9_DATA, `GPB_OFS_PORTA_DATA};
    logic [7:0] dir_ofs [9] = '{`GPB_OFS_PORT0_DIR, `GPB_OFS_PORT1_DIR, `GPB_OFS_PORT2_DIR,
        `GPB_OFS_PORT3_DIR, `GPB_OFS_PORT4_DIR, `GPB_OFS_PORT5_DIR, `GPB_OFS_PORT6_DIR,
        `GPB_OFS_PORT9_DIR, `GPB_OFS_PORTA_DIR};
    // mixed directions so output and input bits sit side by side in one nibble
    gpb_row_t rows [9] = '{'{0, 4'hF, 4'h9, 4'h6, 4'h9, 4'h0}, '{1, 4'h0, 4'h9, 4'h6, 4'h6, 4'hF},
        '{2, 4'h5, 4'hA, 4'h6, 4'h2, 4'hA}, '{3, 4'hC, 4'h3, 4'hF, 4'h3, 4'h3},
        '{4, 4'h1, 4'hF, 4'h0, 4'h1, 4'hE}, '{5, 4'h8, 4'h8, 4'h7, 4'hF, 4'h7},
        '{6, 4'h0, 4'h5, 4'hA, 4'h5, 4'h0}, '{7, 4'h5, 4'hA, 4'h6, 4'hE, 4'h5},
        '{8, 4'hF, 4'h3, 4'hC, 4'hC, 4'hF}};
    gpb_row_t r;

    always #4 clk_sys_i = ~clk_sys_i;  // 125 MHz

    gpb_port_bank u_gpb_port_bank (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_req_i(sfr_req),
        .rdata_o(rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n));
    gpb_pin_board u_gpb_pin_board (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n), .board_i(board),
        .pin_i(pin_i));

    // ****************************************************************
    // tasks
    // ****************************************************************
    // one access, held over one rising edge; no clear, so back-to-back stays clean
    task automatic sfr_op(input logic w, input logic rd, input logic [7:0] a,
                          input logic [3:0] d);
        sfr_req = '{wr: w, rd: rd, addr: a, wdata: d};
        @(negedge clk_sys_i);
    endtask

    // drop both strobes for n cycles
    task automatic sfr_idle(input int n);
        sfr_req = '0;
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // watchdog: whole run is about 130 cycles
    // ****************************************************************
    initial begin
        #20000;
        n_mismatch++;
        end_of_test();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(negedge clk_sys_i);
        rst_i = 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            board[r.idx] = r.board;
            sfr_op(1'b1, 1'b0, dir_ofs[r.idx], r.dir);
            sfr_op(1'b1, 1'b0, data_ofs[r.idx], r.data);
            sfr_idle(3);  // let the pin synchronizer settle
            check("pin_o", pin_o[r.idx], r.data);
            check("pin_oe_n", pin_oe_n[r.idx], r.oe_n);
            sfr_op(1'b0, 1'b1, data_ofs[r.idx], 4'h0);
            check("data read", rdata, r.rd);
            sfr_op(1'b0, 1'b1, dir_ofs[r.idx], 4'h0);
            check("dir read", rdata, r.dir);
            sfr_idle(1);
        end
        // pin must not move before the write's rising edge, then move on it
        sfr_req = '{wr: 1'b1, rd: 1'b0, addr: `GPB_OFS_PORTA_DATA, wdata: 4'h6};
        #2 check("pin_o early", pin_o[8], 4'h3);
        @(negedge clk_sys_i) check("pin_o late", pin_o[8], 4'h6);
        // back-to-back writes, then an unmapped write that must change nothing
        sfr_op(1'b1, 1'b0, `GPB_OFS_PORT1_DATA, 4'h7);
        sfr_op(1'b1, 1'b0, `GPB_OFS_PORT2_DATA, 4'hC);
        sfr_op(1'b1, 1'b0, 8'h07, 4'hF);
        sfr_op(1'b0, 1'b1, 8'h07, 4'h0);
        check("unmapped read", rdata, 4'h0);
        check("pin_o all", pin_o, 36'h6A58F3C79);
        sfr_idle(1);
        // reset in mid-run clears data and direction at once
        rst_i = 1'b1;
        #1 check("pin_o rst", pin_o, 36'h0);
        check("pin_oe_n rst", pin_oe_n, 36'h000FFFFFF);
        check("rdata rst", rdata, 4'h0);
        repeat (16) @(negedge clk_sys_i);
        rst_i = 1'b0;
        for (int p = 0; p < 9; p++) begin
            sfr_op(1'b0, 1'b1, dir_ofs[p], 4'h0);
            check("dir rst", rdata, 4'h0);
            sfr_op(1'b0, 1'b1, data_ofs[p], 4'h0);
            if (p > 5) check("data rst", rdata, 4'h0);
            else check("data rst in", rdata, board[p]);
        end
        sfr_idle(1);
        end_of_test();
    end
endmodule

`default_nettype wire
